// [drv_seq_regs.svh]
// Constants for the drive enable, reset and fault sequencer.
// Assumes a 50 MHz master clock; all times are kept in milliseconds
// and turned into cycle counts here.
`ifndef DRV_SEQ_REGS_SVH
`define DRV_SEQ_REGS_SVH

// Clock rate in kHz, so that milliseconds times this give cycles.
`define DRV_CLK_KHZ       50000
// Longest post-disable current ramp, in milliseconds.
`define DRV_RAMP_MS       275
// Initialisation time after reset release or power-up, in milliseconds.
`define DRV_INIT_MS       325
// Half period of the minor fault blink, in milliseconds.
`define DRV_BLINK_MS      250
`define DRV_RAMP_CYC      (`DRV_RAMP_MS * `DRV_CLK_KHZ)
`define DRV_INIT_CYC      (`DRV_INIT_MS * `DRV_CLK_KHZ)
`define DRV_BLINK_CYC     (`DRV_BLINK_MS * `DRV_CLK_KHZ)

// Register byte addresses.
`define DRV_ADDR_STATUS   4'h0
`define DRV_ADDR_PHASE    4'h4
`define DRV_ADDR_SWITCH   4'h8
`define DRV_ADDR_CTRL     4'hc

// Control register fields.
`define DRV_CTRL_SOFT_DIS 0
`define DRV_CTRL_CLR_MIN  1

// Status register fields.
`define DRV_STAT_CONDUCT  0
`define DRV_STAT_MINOR    1
`define DRV_STAT_MAJOR    2
`define DRV_STAT_STATE    3

// Full current level and phase reset value.
`define DRV_CUR_FULL      8'hff
`define DRV_PHASE_RST     8'h00

`endif

// [drv_seq_pkg.sv]
// Types shared by the sequencer and its users.
// Assumes the constants header is compiled alongside.
package drv_seq_pkg;

   // One-hot sequencer states.
   typedef enum logic [4:0] {
      ST_HOLD = 5'b00001, // Reset input active, no current.
      ST_INIT = 5'b00010, // Initialising after reset or power-up.
      ST_DIS  = 5'b00100, // Disabled, no current.
      ST_RAMP = 5'b01000, // Current ramping after disable release.
      ST_RUN  = 5'b10000  // Normal operation.
   } state_type;

   // Latched switch settings.
   typedef struct packed {
      logic       pulse_fmt; // Step and direction versus two pulses.
      logic       waveform;  // Output waveform select.
      logic [1:0] step_res;  // Step resolution select.
   } switch_type;

endpackage : drv_seq_pkg

// [pin_sync.sv]
// Two-stage synchroniser for a group of asynchronous pin inputs.
// Assumes each bit is independent; no word coherence is promised.
`timescale 1ns/1ns
module pin_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,  // Master clock.
   input  wire logic         i_rst_n, // Asynchronous reset, active low.
   input  wire logic         i_ce,    // Clock enable.
   input  wire logic [W-1:0] i_d,     // Asynchronous pin levels.
   output logic      [W-1:0] o_q      // Synchronised levels.
);

   logic [W-1:0] meta_q;

   // The first stage feeds only the second, to keep metastability out.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         o_q    <= '0;
      end else if (i_ce) begin
         meta_q <= i_d;
         o_q    <= meta_q;
      end
   end

endmodule : pin_sync

// [drive_enable_reset_fault_sequencer.sv]
// Enable, reset and fault sequencing for a stepper drive.
// Assumes the disable, reset, step, direction and switch inputs come
// straight from isolated pins, and that the major fault event comes from
// power stage logic on the same clock.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ns
`include "drv_seq_regs.svh"

// How it works
// - Disable active drops winding current to zero at once.
// - Step and direction pulses are ignored while disabled.
// - The commutation phase is held through disable and reused.
// - After disable release current ramps up in steps within 275 ms.
// - Steps are not acted on until the ramp has finished.
// - A step during the ramp records a step-window minor fault.
// - A minor fault blinks the indicator but keeps the drive running.
// - The fault output stays off while disabled and while ramping.
// - Reset input active removes motor current.
// - Reset input active reloads the switch settings.
// - Reset input active clears a latched major fault.
// - Fault output stays off during reset and 325 ms after release, unless a disable during initialisation hands over to the ramp.
// - A step before initialisation ends is a step-window violation.
// - The fault output conducts only in normal operation without a major fault.
module drive_enable_reset_fault_sequencer #(
   parameter int RAMP_CYC  = `DRV_RAMP_CYC,  // Longest ramp, cycles.
   parameter int INIT_CYC  = `DRV_INIT_CYC,  // Initialisation, cycles.
   parameter int BLINK_CYC = `DRV_BLINK_CYC  // Blink half period.
) (
   input  wire logic                   i_mclk,       // Master clock.
   input  wire logic                   i_rst_n,      // Async reset.
   input  wire logic                   i_ce,         // Clock enable.
   input  wire logic                   i_disable,    // Disable pin.
   input  wire logic                   i_reset_in,   // Reset pin.
   input  wire logic                   i_step,       // Step pin.
   input  wire logic                   i_dir,        // Direction pin.
   input  wire logic                   i_sw_fmt,     // Pulse format.
   input  wire logic                   i_sw_wave,    // Waveform.
   input  wire logic [1:0]             i_sw_res,     // Resolution.
   input  wire logic                   i_major_evt,  // Major fault pulse.
   input  wire logic [3:0]             i_addr,       // Register address.
   input  wire logic [31:0]            i_wdata,      // Write data.
   input  wire logic                   i_wr,         // Write strobe.
   input  wire logic                   i_rd,         // Read strobe.
   output logic      [31:0]            o_rdata,      // Read data.
   output logic      [7:0]             o_current,    // Current level.
   output logic      [7:0]             o_phase,      // Commutation phase.
   output logic                        o_step_acc,   // Step taken pulse.
   output logic                        o_fault_conduct, // High: normal.
   output logic                        o_motor_fault_indicator, // LED.
   output drv_seq_pkg::switch_type     o_switch,     // Latched switches.
   output drv_seq_pkg::state_type      o_state       // Sequencer state.
);
   import drv_seq_pkg::*;

   // Cycles between current increments; 255 steps fit inside the ramp.
   localparam int PRE_RAW = RAMP_CYC / 255;
   localparam int PRE_CYC = (PRE_RAW < 1) ? 1 : PRE_RAW;

   logic [7:0] pins_s;
   logic       dis_s;
   logic       rst_s;
   logic       step_s;
   logic       dir_s;
   logic       step_prev_q;
   logic       step_rise;
   logic       soft_dis_q;
   logic       dis_act;
   state_type  state_q;
   state_type  state_d;
   logic [31:0] timer_q;
   logic [31:0] pre_q;
   logic        pre_tick;
   logic        init_done;
   logic [7:0]  cur_q;
   logic [7:0]  phase_q;
   logic        major_q;
   logic        minor_q;
   logic        clr_min;
   logic [31:0] blink_cnt_q;
   logic        blink_q;
   switch_type  sw_q;
   logic        acc_q;
   logic        conduct_q;
   logic [31:0] rdata_q;

   // Phase advance per step for each resolution setting.
   function automatic logic [7:0] phase_inc(input logic [1:0] res);
      case (res)
         2'h0:    phase_inc = 8'h40;
         2'h1:    phase_inc = 8'h10;
         2'h2:    phase_inc = 8'h04;
         default: phase_inc = 8'h01;
      endcase
   endfunction : phase_inc

   // Every pin crosses two flip-flops before any logic looks at it.
   pin_sync #(
      .W (8)
   ) u_pins (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_d     ({i_disable, i_reset_in, i_step, i_dir,
                 i_sw_fmt, i_sw_wave, i_sw_res}),
      .o_q     (pins_s)
   );

   assign dis_s  = pins_s[7];
   assign rst_s  = pins_s[6];
   assign step_s = pins_s[5];
   assign dir_s  = pins_s[4];

   // Software disable acts exactly like the disable pin.
   assign dis_act   = dis_s | soft_dis_q;
   assign step_rise = step_s & ~step_prev_q;
   assign pre_tick  = (pre_q == 32'(PRE_CYC - 1));
   assign init_done = (timer_q >= 32'(INIT_CYC - 1));

   // Step edge detection works on the synchronised level only.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         step_prev_q <= 1'b0;
      end else if (i_ce) begin
         step_prev_q <= step_s;
      end
   end

   // Next state; the reset input overrides everything else.
   always_comb begin
      state_d = state_q;
      if (rst_s) begin
         state_d = ST_HOLD;
      end else begin
         case (state_q)
            ST_HOLD: begin
               state_d = ST_INIT;
            end
            ST_INIT: begin
               if (dis_act) begin
                  state_d = ST_DIS;
               end else if (init_done && cur_q == `DRV_CUR_FULL) begin
                  state_d = ST_RUN;
               end
            end
            ST_DIS: begin
               if (!dis_act) begin
                  state_d = ST_RAMP;
               end
            end
            ST_RAMP: begin
               if (dis_act) begin
                  state_d = ST_DIS;
               end else if (cur_q == `DRV_CUR_FULL) begin
                  state_d = ST_RUN;
               end
            end
            ST_RUN: begin
               if (dis_act) begin
                  state_d = ST_DIS;
               end
            end
            default: begin
               state_d = ST_HOLD;
            end
         endcase
      end
   end

   // Power-up lands in the hold state so it runs the reset sequence.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= ST_HOLD;
      end else if (i_ce) begin
         state_q <= state_d;
      end
   end

   // Initialisation timer restarts whenever the state changes.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_q <= '0;
      end else if (i_ce) begin
         if (state_d != state_q || state_q != ST_INIT) begin
            timer_q <= '0;
         end else if (!init_done) begin
            timer_q <= timer_q + 32'h1;
         end
      end
   end

   // Ramp prescaler runs only in the ramp and initialisation states.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pre_q <= '0;
      end else if (i_ce) begin
         if ((state_q != ST_RAMP && state_q != ST_INIT) || pre_tick) begin
            pre_q <= '0;
         end else begin
            pre_q <= pre_q + 32'h1;
         end
      end
   end

   // Current drops at once and climbs one step per tick, which keeps
   // the torque from jerking the rotor off its held phase.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cur_q <= 8'h00;
      end else if (i_ce) begin
         if (rst_s || dis_act || major_q || state_q == ST_HOLD ||
             state_q == ST_DIS) begin
            cur_q <= 8'h00;
         end else if (state_q == ST_RUN) begin
            cur_q <= `DRV_CUR_FULL;
         end else if (pre_tick && cur_q != `DRV_CUR_FULL) begin
            cur_q <= cur_q + 8'h01;
         end
      end
   end

   // Steps move the phase only in normal operation without a major fault.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         phase_q <= `DRV_PHASE_RST;
         acc_q   <= 1'b0;
      end else if (i_ce) begin
         acc_q <= 1'b0;
         if (state_q == ST_HOLD) begin
            phase_q <= `DRV_PHASE_RST;
         end else if (step_rise && state_q == ST_RUN && !dis_act &&
                      !major_q) begin
            acc_q <= 1'b1;
            if (dir_s) begin
               phase_q <= phase_q + phase_inc(sw_q.step_res);
            end else begin
               phase_q <= phase_q - phase_inc(sw_q.step_res);
            end
         end
         // Outside the branch above the phase is simply kept.
      end
   end

   // Switches follow the pins in hold and while initialising. At power-up
   // the hold state lasts one edge while the pin synchroniser is still
   // empty, so the settings are only trusted once initialisation ends.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sw_q <= '0;
      end else if (i_ce) begin
         if (state_q == ST_HOLD || state_q == ST_INIT) begin
            sw_q <= switch_type'(pins_s[3:0]);
         end
      end
   end

   // Major fault latches until the reset input clears it.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         major_q <= 1'b0;
      end else if (i_ce) begin
         if (rst_s || state_q == ST_HOLD) begin
            major_q <= 1'b0;
         end else if (i_major_evt) begin
            major_q <= 1'b1;
         end
      end
   end

   // A step too early sets the minor flag; a set beats a clear.
   assign clr_min = i_wr && i_addr == `DRV_ADDR_CTRL &&
                    i_wdata[`DRV_CTRL_CLR_MIN];

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         minor_q <= 1'b0;
      end else if (i_ce) begin
         if (step_rise && (state_q == ST_RAMP || state_q == ST_INIT)) begin
            minor_q <= 1'b1;
         end else if (clr_min || state_q == ST_HOLD) begin
            minor_q <= 1'b0;
         end
      end
   end

   // Blink timer for the minor fault; it free-runs only while needed.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         blink_cnt_q <= '0;
         blink_q     <= 1'b0;
      end else if (i_ce) begin
         if (!minor_q) begin
            blink_cnt_q <= '0;
            blink_q     <= 1'b0;
         end else if (blink_cnt_q == 32'(BLINK_CYC - 1)) begin
            blink_cnt_q <= '0;
            blink_q     <= ~blink_q;
         end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
         end
      end
   end

   // Fault output conducts only in normal running without a major fault,
   // so a dead drive reads the same as a faulted one.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         conduct_q <= 1'b0;
      end else if (i_ce) begin
         conduct_q <= (state_d == ST_RUN) && !major_q && !rst_s &&
                      !dis_act;
      end
   end

   // Software disable bit; the clear bit is a write pulse only.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         soft_dis_q <= 1'b0;
      end else if (i_ce) begin
         if (i_wr && i_addr == `DRV_ADDR_CTRL) begin
            soft_dis_q <= i_wdata[`DRV_CTRL_SOFT_DIS];
         end
      end
   end

   // Read data stands for the one cycle after the read strobe.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= '0;
      end else if (i_ce) begin
         rdata_q <= '0;
         if (i_rd) begin
            case (i_addr)
               `DRV_ADDR_STATUS: begin
                  rdata_q[`DRV_STAT_CONDUCT] <= conduct_q;
                  rdata_q[`DRV_STAT_MINOR]   <= minor_q;
                  rdata_q[`DRV_STAT_MAJOR]   <= major_q;
                  rdata_q[`DRV_STAT_STATE +: 5] <= state_q;
               end
               `DRV_ADDR_PHASE: begin
                  rdata_q[7:0] <= phase_q;
               end
               `DRV_ADDR_SWITCH: begin
                  rdata_q[3:0] <= sw_q;
               end
               `DRV_ADDR_CTRL: begin
                  rdata_q[`DRV_CTRL_SOFT_DIS] <= soft_dis_q;
               end
               default: begin
                  rdata_q <= '0;
               end
            endcase
         end
      end
   end

   // Outputs come from flip-flops; the indicator is gated from three of them.
   assign o_rdata                 = rdata_q;
   assign o_current               = cur_q;
   assign o_phase                 = phase_q;
   assign o_step_acc              = acc_q;
   assign o_fault_conduct         = conduct_q;
   assign o_motor_fault_indicator = major_q | (minor_q & blink_q);
   assign o_switch                = sw_q;
   assign o_state                 = state_q;

endmodule : drive_enable_reset_fault_sequencer

// [drv_seq_monitor.sv]
// Concurrent checks on the ports of the drive sequencer.
// Assumes i_ce is held high, so every clock edge is a working edge.
`timescale 1ns/1ns
module drv_seq_monitor
   import drv_seq_pkg::*;
#(
   parameter int RAMP_CYC = 510, // Ramp length, cycles.
   parameter int INIT_CYC = 600  // Initialisation, cycles.
) (
   input wire logic       i_mclk,          // Master clock.
   input wire logic       i_rst_n,         // Async reset, active low.
   input wire logic       i_disable,       // Disable pin.
   input wire logic       i_reset_in,      // Reset pin.
   input wire logic       i_major_evt,     // Major fault pulse.
   input wire logic [7:0] o_current,       // Current level.
   input wire logic [7:0] o_phase,         // Commutation phase.
   input wire logic       o_step_acc,      // Step taken pulse.
   input wire logic       o_fault_conduct, // High when ready.
   input wire state_type  o_state          // Sequencer state.
);
   localparam int RAMP_LIM = RAMP_CYC + 16;
   logic [31:0] init_cnt_q;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   // Cycles spent initialising; a short stay would report ready too early.
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) init_cnt_q <= 32'h0;
      else if (o_state == ST_INIT) init_cnt_q <= init_cnt_q + 32'h1;
      else init_cnt_q <= 32'h0;
   end
   // The pin synchroniser allows a few cycles before each pin acts.
   AST_DIS_CUT: assert property (i_disable [*5] |-> o_current == 8'h00)
      else $error("current left on while disabled");
   AST_DIS_NO_STEP: assert property (i_disable [*8] |-> !o_step_acc)
      else $error("step taken while disabled");
   AST_PHASE_KEPT: assert property ((o_state inside {ST_DIS, ST_RAMP}) &&
      ($past(o_state) inside {ST_DIS, ST_RAMP}) |-> $stable(o_phase))
      else $error("phase moved while disabled or ramping");
   AST_RAMP_BOUND: assert property ($rose(o_state == ST_RAMP) |->
      ##[1:RAMP_LIM] o_state != ST_RAMP) else $error("ramp too long");
   AST_RAMP_SMOOTH: assert property (o_state == ST_RAMP |->
      (o_current - $past(o_current)) <= 8'h01) else $error("current jumped");
   AST_EARLY_IGNORED: assert property (o_state inside {ST_INIT, ST_RAMP}
      |-> !o_step_acc) else $error("step taken before ready");
   AST_FAULT_OFF: assert property ((i_disable || i_reset_in) [*5] |->
      !o_fault_conduct) else $error("fault output conducts");
   AST_RST_CUT: assert property (i_reset_in [*5] |-> o_current == 8'h00)
      else $error("current left on in reset");
   AST_INIT_LEN: assert property ($past(o_state) == ST_INIT &&
      o_state == ST_RUN |-> $past(init_cnt_q) >= INIT_CYC - 2)
      else $error("initialisation too short");
   AST_CONDUCT_RUN: assert property (o_fault_conduct |-> o_state == ST_RUN
      || $past(o_state) == ST_RUN) else $error("conducts outside run");
   AST_READY: assert property ($rose(o_state == ST_RUN) |=> o_fault_conduct)
      else $error("ready not shown after run entry");
   AST_MAJOR_OFF: assert property (i_major_evt |-> ##[1:3]
      (!o_fault_conduct && o_current == 8'h00)) else $error("major ignored");
   COV_RUN: cover property ($rose(o_state == ST_RUN));
   COV_STEP: cover property (o_state == ST_RUN && o_step_acc);
   COV_MAJOR: cover property (i_major_evt);
endmodule : drv_seq_monitor
bind drive_enable_reset_fault_sequencer drv_seq_monitor #(
   .RAMP_CYC(RAMP_CYC), .INIT_CYC(INIT_CYC)) i_drv_seq_monitor (.i_mclk,
   .i_rst_n, .i_disable, .i_reset_in, .i_major_evt, .o_current, .o_phase,
   .o_step_acc, .o_fault_conduct, .o_state);

// [step_indexer.sv]
// Indexer model: sends bursts of step pulses and a direction level.
// Assumes the drive's fault output is high while it is ready.
`timescale 1ns/1ns
module step_indexer (
   input  wire logic       i_mclk,  // Clock.
   input  wire logic       i_go,    // Start a burst.
   input  wire logic [7:0] i_count, // Steps in the burst.
   input  wire logic       i_cw,    // Direction of the burst.
   input  wire logic       i_wait,  // Wait for ready before a step.
   input  wire logic       i_ready, // Fault output, high when ready.
   output logic            o_step,  // Step pin.
   output logic            o_dir,   // Direction pin.
   output logic            o_busy   // Burst in progress.
);
   logic [7:0] left_q = 8'h00;
   logic [2:0] ph_q = 3'h0;
   logic       step_q = 1'b0;
   logic       dir_q = 1'b0;
   // Four cycles high and four low, so the pin synchroniser sees each edge.
   always @(posedge i_mclk) begin
      if (i_go) begin
         left_q <= i_count;
         dir_q <= i_cw;
         ph_q <= 3'h0;
      end else if (left_q != 8'h00 &&
                   (ph_q != 3'h0 || !i_wait || i_ready)) begin
         ph_q <= ph_q + 3'h1;
         step_q <= (ph_q < 3'h4);
         if (ph_q == 3'h7) left_q <= left_q - 8'h01;
      end else step_q <= 1'b0;
   end
   // Pins follow the internal state.
   assign o_step = step_q;
   assign o_dir = dir_q;
   assign o_busy = (left_q != 8'h00);
endmodule : step_indexer

// [drive_enable_reset_fault_sequencer_bench.sv]
// Self-checking bench for the drive enable, reset and fault sequencer.
// Assumes the package, the indexer model and the checker come first.
`timescale 1ns/1ns
`include "drv_seq_regs.svh"
module drive_enable_reset_fault_sequencer_bench;
   import drv_seq_pkg::*;
   localparam int RAMP = 510;
   localparam int INIT = 600;
   logic i_mclk, i_rst_n, i_disable, i_reset_in, i_step, i_dir, i_sw_fmt;
   logic i_sw_wave, i_major_evt, i_wr, i_rd, i_go, i_cw, i_wait, o_busy;
   logic o_step_acc, o_fault_conduct, o_motor_fault_indicator;
   logic [1:0] i_sw_res;
   logic [3:0] i_addr;
   logic [7:0] i_count, o_current, o_phase, p0;
   logic [31:0] i_wdata, o_rdata, d;
   switch_type o_switch;
   state_type o_state;
   int errors = 0, total_checks = 0, acc_cnt = 0, a0;
   time rel_t;
   drive_enable_reset_fault_sequencer #(.RAMP_CYC(RAMP), .INIT_CYC(INIT),
      .BLINK_CYC(8)) i_drive_enable_reset_fault_sequencer (.i_mclk,
      .i_rst_n, .i_ce(1'b1), .i_disable, .i_reset_in, .i_step, .i_dir,
      .i_sw_fmt, .i_sw_wave, .i_sw_res, .i_major_evt, .i_addr, .i_wdata,
      .i_wr, .i_rd, .o_rdata, .o_current, .o_phase, .o_step_acc,
      .o_fault_conduct, .o_motor_fault_indicator, .o_switch, .o_state);
   step_indexer i_step_indexer (.i_mclk, .i_go, .i_count, .i_cw, .i_wait,
      .i_ready(o_fault_conduct), .o_step(i_step), .o_dir(i_dir), .o_busy);
   // Clock at 50 MHz and a count of accepted steps.
   always #10 i_mclk = ~i_mclk;
   always @(posedge i_mclk) if (o_step_acc === 1'b1) acc_cnt++;
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : test_done
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic ticks(input int n);
      repeat (n) @(posedge i_mclk);
   endtask : ticks
   // Read data are taken in the one cycle where they stand.
   task automatic bus_rd(input logic [3:0] a);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      @(posedge i_mclk);
      d = o_rdata;
   endtask : bus_rd
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask : bus_wr
   // Waits for ready; a hang counts as a mismatch and ends the run.
   task automatic wait_ready(input int lim);
      int k;
      for (k = 0; o_fault_conduct !== 1'b1; k++) begin
         if (k == lim) begin
            errors++;
            test_done();
         end
         @(posedge i_mclk);
      end
   endtask : wait_ready
   task automatic burst(input logic [7:0] n, input logic cw, input logic wt);
      int k;
      i_go <= 1'b1;
      i_count <= n;
      i_cw <= cw;
      i_wait <= wt;
      @(posedge i_mclk);
      i_go <= 1'b0;
      @(posedge i_mclk);
      for (k = 0; o_busy === 1'b1; k++) begin
         if (k == 3000) begin
            errors++;
            test_done();
         end
         @(posedge i_mclk);
      end
      ticks(8);
   endtask : burst
   task automatic t_power();
      ticks(4);
      chk(32'(o_fault_conduct), 32'h0);
      chk(32'(o_state), 32'(ST_INIT));
      wait_ready(INIT + 60);
      chk(32'(($time - rel_t) / 20 >= INIT), 32'h1);
      chk(32'(o_current), 32'hff);
      chk(32'(o_switch), 32'ha);
      $display("power-up test done");
   endtask : t_power
   task automatic t_steps();
      p0 = o_phase;
      a0 = acc_cnt;
      burst(8'h03, 1'b1, 1'b1);
      chk(32'(acc_cnt - a0), 32'h3);
      chk(32'(o_phase), 32'(p0 + 8'h0c));
      bus_rd(`DRV_ADDR_STATUS);
      chk(d, 32'h81);
      bus_rd(4'h2);
      chk(d, 32'h0);
      $display("step test done");
   endtask : t_steps
   // Disable is applied only with the indexer idle.
   task automatic t_disable();
      int k, tg;
      logic prv;
      p0 = o_phase;
      a0 = acc_cnt;
      i_disable <= 1'b1;
      ticks(6);
      chk(32'(o_current), 32'h0);
      chk(32'(o_fault_conduct), 32'h0);
      burst(8'h02, 1'b1, 1'b0);
      chk(32'(acc_cnt - a0), 32'h0);
      bus_rd(`DRV_ADDR_STATUS);
      chk(32'(d[1]), 32'h0);
      i_disable <= 1'b0;
      ticks(6);
      chk(32'(o_state), 32'(ST_RAMP));
      burst(8'h01, 1'b1, 1'b0);
      chk(32'(acc_cnt - a0), 32'h0);
      chk(32'(o_fault_conduct), 32'h0);
      bus_rd(`DRV_ADDR_STATUS);
      chk(32'(d[1]), 32'h1);
      chk(32'(o_phase), 32'(p0));
      wait_ready(RAMP + 40);
      chk(32'(o_current), 32'hff);
      burst(8'h01, 1'b1, 1'b1);
      chk(32'(acc_cnt - a0), 32'h1);
      tg = 0;
      prv = o_motor_fault_indicator;
      for (k = 0; k < 40; k++) begin
         @(posedge i_mclk);
         if (o_motor_fault_indicator !== prv) tg++;
         prv = o_motor_fault_indicator;
      end
      chk(32'(tg >= 2 && o_fault_conduct === 1'b1), 32'h1);
      bus_wr(`DRV_ADDR_CTRL, 32'h2);
      bus_rd(`DRV_ADDR_STATUS);
      chk(d, 32'h81);
      $display("disable test done");
   endtask : t_disable
   task automatic t_reset();
      i_major_evt <= 1'b1;
      @(posedge i_mclk);
      i_major_evt <= 1'b0;
      i_sw_fmt <= 1'b0;
      i_sw_wave <= 1'b1;
      i_sw_res <= 2'h3;
      ticks(6);
      chk(32'(o_fault_conduct), 32'h0);
      chk(32'(o_motor_fault_indicator), 32'h1);
      chk(32'(o_switch), 32'ha);
      i_reset_in <= 1'b1;
      ticks(6);
      chk(32'(o_current), 32'h0);
      chk(32'(o_fault_conduct), 32'h0);
      i_reset_in <= 1'b0;
      rel_t = $time;
      ticks(6);
      chk(32'(o_switch), 32'h7);
      bus_rd(`DRV_ADDR_STATUS);
      chk(32'(d[2]), 32'h0);
      burst(8'h01, 1'b1, 1'b0);
      bus_rd(`DRV_ADDR_STATUS);
      chk(32'(d[1]), 32'h1);
      wait_ready(INIT + 60);
      chk(32'(($time - rel_t) / 20 >= INIT), 32'h1);
      p0 = o_phase;
      burst(8'h02, 1'b0, 1'b1);
      chk(32'(o_phase), {24'h0, p0 - 8'h02});
      bus_rd(`DRV_ADDR_SWITCH);
      chk(d, 32'h7);
      // Software disable must act like the pin and keep the phase.
      bus_wr(`DRV_ADDR_CTRL, 32'h1);
      bus_rd(`DRV_ADDR_CTRL);
      chk(d, 32'h1);
      chk(32'(o_fault_conduct), 32'h0);
      chk(32'(o_current), 32'h0);
      bus_wr(`DRV_ADDR_CTRL, 32'h0);
      wait_ready(RAMP + 40);
      bus_rd(`DRV_ADDR_PHASE);
      chk(d, {24'h0, p0 - 8'h02});
      $display("reset test done");
   endtask : t_reset
   // Main sequence: reset for six cycles, then the scenarios in turn.
   initial begin
      {i_mclk, i_rst_n, i_disable, i_reset_in, i_major_evt} = 5'h0;
      {i_wr, i_rd, i_go, i_cw, i_wait, i_sw_wave} = 6'h0;
      i_sw_fmt = 1'b1;
      i_sw_res = 2'h2;
      i_addr = 4'h0;
      i_wdata = 32'h0;
      i_count = 8'h00;
      ticks(6);
      i_rst_n <= 1'b1;
      rel_t = $time;
      t_power();
      t_steps();
      t_disable();
      t_reset();
      test_done();
   end
endmodule : drive_enable_reset_fault_sequencer_bench
